// file: design/clock_gen_defs.vh
`ifndef CLOCK_GEN_DEFS_VH
`define CLOCK_GEN_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_PROC_CLK_CTRL 4'h0
`define OFS_PLL_CONTROL 4'h1
`define OFS_PORT_CTRL 4'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCC_DIV_LSB 0
`define PCC_DIV_MSB 2
`define PCC_SUB_SEL 3
`define PCC_SRC_STAT 4
`define PCC_FB_OFF 5
`define PCC_MAIN_STOP 6
`define PLL_RUN 0
`define PLL_SELECT 1
`define PLL_GUARD 2
`define PORT_CLOCK_OUT_PIN_SEL 1

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define PCC_RESET 8'h03
`define PCC_DIV_RESET 3'h3
`define PLL_RESET 8'h01
`define PORT_RESET 8'h00
`define PLL_WR_MASK 8'h07
`define DIV_MAX_CODE 3'h5

// ----------------------------------------------------------------
// Power modes
// ----------------------------------------------------------------
`define MODE_NORMAL 3'h0
`define MODE_STAB 3'h1
`define MODE_HALT 3'h2
`define MODE_IDLE 3'h3
`define MODE_STOP 3'h4
`define MODE_SUB_IDLE 3'h5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PLL_FACTOR 4
`define PHASE_LAST 2'h3

`endif

// file: design/tick_divider.v
`default_nettype none
`include "clock_gen_defs.vh"

// ----------------------------------------------------------------
// Power-of-two tick divider, code changes taken at wrap only
// ----------------------------------------------------------------
module tick_divider #(
  parameter CW = 5
) (
  input wire clk,
  input wire rst,
  input wire tick_in,
  input wire [2:0] sel,
  output wire tick_out
);

  reg [CW-1:0] cnt_q;
  reg [2:0] sel_q;
  reg tick_q;
  wire [CW:0] span;
  wire [CW-1:0] lim;

  assign span = {{CW{1'b0}}, 1'b1} << sel_q;
  assign lim = span[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
  assign tick_out = tick_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= {CW{1'b0}};
      sel_q <= 3'h3;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (tick_in) begin
        if (cnt_q >= lim) begin
          cnt_q <= {CW{1'b0}};
          tick_q <= 1'b1;
          if (sel <= `DIV_MAX_CODE) begin
            sel_q <= sel; // [R19]
          end
        end else begin
          cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: design/clock_gen_pll_clock_out_pin.v
// What this block does
// R1 - Main oscillator stops in reset and STOP, and in subclock with stop bit.
// R2 - System clock runs only in normal, subclock operation and HALT.
// R3 - Peripheral prescaler runs only in HALT or operation with main osc on.
// R4 - Clock output carries the system clock chosen by clock-select bits.
// R5 - Clock drives the shared pin only when port control selects it.
// R6 - Pin held low while system clock stopped, toggles while it runs.
// R7 - After reset the shared pin is an undriven port input.
// R8 - External clock needs feedback resistor off; stabilization wait still used.
// R9 - Multiplied mode gives four times oscillator rate; clock-through passes it.
// R10 - PLL control is 8 bits, resets to 01, upper five bits read zero.
// R11 - After reset PLL runs with clock-through; select bit picks multiplied.
// R12 - Software sets run, waits 200 us for lock, then sets select.
// R13 - Software clears select, waits eight clocks, then clears run.
// R14 - Software drops PLL before IDLE or STOP, restores it on wake.
// R15 - Software clears run bit after reset when PLL is unused.
// R16 - PLL may keep running in IDLE; it must be off before STOP.
// R17 - Divider codes give main clock over 1 to 32; top bit picks subclock.
// R18 - Source status bit follows the real switch, within one subclock period.
// R19 - Clock switches happen at boundaries so no short pulse escapes.
//
// Design decisions made here: the register offsets and the plain strobed port.
`default_nettype none
`include "clock_gen_defs.vh"

module clock_gen_pll_clock_out_pin #(
  parameter PRESCALE_W = 10
) (
  input wire clk,
  input wire rst,
  input wire [2:0] power_mode,
  input wire sub_clk_tick,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  output reg main_osc_en,
  output wire sub_osc_en,
  output reg cpu_clk_en,
  output reg sys_clk_tick,
  output reg periph_clk_tick,
  output reg [PRESCALE_W-1:0] periph_prescale,
  output reg multiplier_run,
  output reg feedback_resistor_off,
  output reg output_guard_stop,
  output reg clock_out_pin_o,
  output reg clock_out_pin_oe
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [2:0] divider_select_q;
  reg subclock_select_q;
  reg clock_source_status_q;
  reg main_osc_stop_q;
  reg fb_off_q;
  reg run_q;
  reg select_q;
  reg guard_q;
  reg shared_port_bit_q;
  reg [1:0] phase_q;
  reg pll_active_q;
  reg clock_out_pin_q;
  reg [PRESCALE_W-1:0] presc_q;

  wire [7:0] pcc_val;
  wire [7:0] pll_val;
  wire [7:0] port_val;
  wire osc_run;
  wire sys_run;
  wire periph_run;
  wire osc_tick;
  wire fxx_tick;
  wire div_tick;
  wire sys_tick;

  assign sub_osc_en = 1'b1;

  // ----------------------------------------------------------------
  // Register write port
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      divider_select_q <= `PCC_DIV_RESET;
      subclock_select_q <= 1'b0;
      fb_off_q <= 1'b0;
      main_osc_stop_q <= 1'b0;
      run_q <= 1'b1; // [R10] [R11]
      select_q <= 1'b0; // [R11]
      guard_q <= 1'b0;
      shared_port_bit_q <= 1'b0; // [R7]
    end else if (wr) begin
      case (addr)
        `OFS_PROC_CLK_CTRL: begin
          divider_select_q <= wdata[`PCC_DIV_MSB:`PCC_DIV_LSB]; // [R17]
          subclock_select_q <= wdata[`PCC_SUB_SEL]; // [R17]
          fb_off_q <= wdata[`PCC_FB_OFF]; // [R8]
          main_osc_stop_q <= wdata[`PCC_MAIN_STOP];
        end
        `OFS_PLL_CONTROL: begin
          run_q <= wdata[`PLL_RUN]; // [R11] [R16]
          select_q <= wdata[`PLL_SELECT]; // [R11]
          guard_q <= wdata[`PLL_GUARD];
        end
        `OFS_PORT_CTRL: begin
          shared_port_bit_q <= wdata[`PORT_CLOCK_OUT_PIN_SEL]; // [R5]
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  assign pcc_val = {1'b0, main_osc_stop_q, fb_off_q, clock_source_status_q,
                    subclock_select_q, divider_select_q};
  assign pll_val = {5'h00, guard_q, select_q, run_q} & `PLL_WR_MASK; // [R10]
  assign port_val = {6'h00, shared_port_bit_q, 1'b0};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `OFS_PROC_CLK_CTRL: rdata <= pcc_val;
        `OFS_PLL_CONTROL: rdata <= pll_val;
        `OFS_PORT_CTRL: rdata <= port_val;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Clock gating by power mode
  // ----------------------------------------------------------------
  assign osc_run = (power_mode != `MODE_STOP) &&
                   !(clock_source_status_q && main_osc_stop_q); // [R1]
  assign sys_run = (power_mode == `MODE_NORMAL) ||
                   (power_mode == `MODE_HALT); // [R2]
  assign periph_run = sys_run && osc_run; // [R3]

  // ----------------------------------------------------------------
  // Oscillator phase and multiplier
  // ----------------------------------------------------------------
  // Fast clock is the multiplied rate; oscillator ticks every fourth cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= 2'h0;
      pll_active_q <= 1'b0;
    end else begin
      if (osc_run) begin
        phase_q <= phase_q + 2'h1;
      end
      if (phase_q == `PHASE_LAST) begin
        pll_active_q <= select_q && run_q; // [R19]
      end
    end
  end

  assign osc_tick = osc_run && (phase_q == `PHASE_LAST);
  assign fxx_tick = pll_active_q ? (osc_run && run_q) : osc_tick; // [R9]

  // ----------------------------------------------------------------
  // Divider for the system clock
  // ----------------------------------------------------------------
  tick_divider #(
    .CW(5)
  ) sys_div (
    .clk(clk),
    .rst(rst),
    .tick_in(fxx_tick),
    .sel(divider_select_q),
    .tick_out(div_tick)
  );

  // ----------------------------------------------------------------
  // Main/subclock source switch
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_source_status_q <= 1'b0;
    end else if (sub_clk_tick) begin
      clock_source_status_q <= subclock_select_q; // [R18]
    end
  end

  assign sys_tick = clock_source_status_q ? sub_clk_tick : div_tick; // [R17]

  // ----------------------------------------------------------------
  // Peripheral prescaler
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_q <= {PRESCALE_W{1'b0}};
    end else if (periph_run && fxx_tick) begin
      presc_q <= presc_q + {{(PRESCALE_W-1){1'b0}}, 1'b1}; // [R3]
    end
  end

  // ----------------------------------------------------------------
  // Clock output pin
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_out_pin_q <= 1'b0;
    end else if (!sys_run) begin
      clock_out_pin_q <= 1'b0; // [R6]
    end else if (sys_tick) begin
      clock_out_pin_q <= ~clock_out_pin_q; // [R4] [R6]
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      main_osc_en <= 1'b0;
      cpu_clk_en <= 1'b0;
      sys_clk_tick <= 1'b0;
      periph_clk_tick <= 1'b0;
      periph_prescale <= {PRESCALE_W{1'b0}};
      multiplier_run <= 1'b0;
      feedback_resistor_off <= 1'b0;
      output_guard_stop <= 1'b0;
      clock_out_pin_o <= 1'b0;
      clock_out_pin_oe <= 1'b0;
    end else begin
      main_osc_en <= osc_run; // [R1]
      cpu_clk_en <= (power_mode == `MODE_NORMAL);
      sys_clk_tick <= sys_run && sys_tick; // [R2]
      periph_clk_tick <= periph_run && fxx_tick; // [R3]
      periph_prescale <= presc_q;
      multiplier_run <= run_q; // [R16]
      feedback_resistor_off <= fb_off_q; // [R8]
      output_guard_stop <= guard_q;
      clock_out_pin_o <= shared_port_bit_q & clock_out_pin_q & sys_run; // [R5] [R6]
      clock_out_pin_oe <= shared_port_bit_q; // [R5] [R7]
    end
  end

endmodule

`default_nettype wire

// file: test/sub_osc_model.sv
`default_nettype none
// ----------------------------------------------------------------
// Subclock source, free running, also during reset
// ----------------------------------------------------------------
module sub_osc_model #(
  parameter int PERIOD = 40
) (
  input wire logic clk,
  output logic sub_clk_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] LAST = 8'(PERIOD - 1);
  logic [7:0] cnt_q = 8'h00;
  logic tick_q = 1'b0;
  assign sub_clk_tick = tick_q;
  always @(posedge clk) begin
    cnt_q <= (cnt_q == LAST) ? 8'h00 : cnt_q + 8'h01;
    tick_q <= (cnt_q == LAST);
  end
endmodule
`default_nettype wire

// file: test/clock_gen_checks_properties.sv
`default_nettype none
module clock_gen_checks (
  input wire clk,
  input wire rst,
  input wire [2:0] power_mode,
  input wire [3:0] addr,
  input wire rd,
  input wire [7:0] rdata,
  input wire main_osc_en,
  input wire cpu_clk_en,
  input wire sys_clk_tick,
  input wire periph_clk_tick,
  input wire clock_out_pin_o,
  input wire clock_out_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [8:0] still_q;
  logic last_q;
  // ----------------------------------------------------------------
  // Cycles since the driven pin last moved in normal mode
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      still_q <= 9'h000;
      last_q <= 1'b0;
    end else begin
      last_q <= clock_out_pin_o;
      if (!clock_out_pin_oe || power_mode != 3'h0 ||
          clock_out_pin_o != last_q) begin
        still_q <= 9'h000;
      end else if (still_q != 9'h1FF) begin
        still_q <= still_q + 9'h001;
      end
    end
  end
  a_sys_gated: assert property (
    power_mode != 3'h0 && power_mode != 3'h2 && $stable(power_mode) &&
    !$past(rst) |-> !sys_clk_tick && !clock_out_pin_o)
    else $error("system clock or pin active while stopped");
  a_cpu_gated: assert property (
    power_mode != 3'h0 && $stable(power_mode) && !$past(rst)
    |-> !cpu_clk_en) else $error("cpu clock outside normal mode");
  a_periph_mode: assert property (
    power_mode != 3'h0 && power_mode != 3'h2 && $stable(power_mode) &&
    !$past(rst) |-> !periph_clk_tick) else $error("periph tick stopped mode");
  a_periph_osc: assert property (
    !main_osc_en && !$past(main_osc_en) |-> !periph_clk_tick)
    else $error("periph tick without main osc");
  a_stop_osc: assert property (
    power_mode == 3'h4 && $stable(power_mode) && !$past(rst)
    |-> !main_osc_en) else $error("main osc runs in stop");
  a_wait_osc: assert property (
    power_mode inside {3'h1, 3'h2, 3'h3} && $stable(power_mode) &&
    !$past(rst) |-> main_osc_en) else $error("main osc off while needed");
  a_pin_hiz: assert property (!clock_out_pin_oe |-> !clock_out_pin_o)
    else $error("pin value while undriven");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
  a_pll_zero: assert property (
    $past(rd) && $past(addr) == 4'h1 |-> rdata[7:3] == 5'h00)
    else $error("pll control upper bits set");
  a_pin_live: assert property (still_q < 9'h12C)
    else $error("clock out pin not toggling");
endmodule
bind clock_gen_pll_clock_out_pin clock_gen_checks chk_i (.clk, .rst, .power_mode,
  .addr, .rd, .rdata, .main_osc_en, .cpu_clk_en, .sys_clk_tick,
  .periph_clk_tick, .clock_out_pin_o, .clock_out_pin_oe);
`default_nettype wire

// file: test/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, wr, rd, tick, osc, sub_en, cpu, sys, per, run, fbr;
  logic guard, pin, oe;
  logic [2:0] mode;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [9:0] pre;
  int failures = 0, comparisons = 0, n, k;
  logic [7:0] row_pcc [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
  int row_gap [6] = '{4, 8, 16, 32, 64, 128};
  clock_gen_pll_clock_out_pin clock_gen_pll_clock_out_pin_i (.clk(clk), .rst(rst),
    .power_mode(mode), .sub_clk_tick(tick), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .main_osc_en(osc), .sub_osc_en(sub_en),
    .cpu_clk_en(cpu), .sys_clk_tick(sys), .periph_clk_tick(per),
    .periph_prescale(pre), .multiplier_run(run), .feedback_resistor_off(fbr),
    .output_guard_stop(guard), .clock_out_pin_o(pin),
    .clock_out_pin_oe(oe));
  sub_osc_model sub_osc_model_i (.clk(clk), .sub_clk_tick(tick));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic gap(output int g);
    int w;
    w = 0;
    while (sys !== 1'b1 && w < 400) begin
      @(negedge clk);
      w++;
    end
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while (sys !== 1'b1 && g < 400);
  endtask
  task automatic ticks(input int c, output int t, output int p);
    t = 0;
    p = 0;
    repeat (c) begin
      @(negedge clk);
      if (sys === 1'b1) t++;
      if (per === 1'b1) p++;
    end
  endtask
  task automatic mode_chk(input logic [2:0] m, input logic o, input logic r);
    @(posedge clk);
    mode <= m;
    repeat (10) @(negedge clk);
    chk(osc, o);
    chk(cpu, m == 3'h0);
    ticks(300, k, n);
    chk(k > 0, r);
    chk(n > 0, r);
  endtask
  task automatic stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #600_000;
    failures++;
    stop_test;
  end
  initial begin
    rst = 1'b1;
    {wr, rd, mode, addr, wdata} = '0;
    repeat (10) @(posedge clk);
    chk({osc, oe, pin}, 3'h0);
    chk({sub_en, pre}, 11'h400);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_reg(4'h0, v);
    chk(v, 8'h03);
    rd_reg(4'h1, v);
    chk(v, 8'h01);
    rd_reg(4'hF, v);
    chk({v, run}, 9'h001);
    $display("reset values done");
    for (int i = 0; i < 6; i++) begin
      wr_reg(4'h0, row_pcc[i]);
      rd_reg(4'h0, v);
      chk(v, row_pcc[i]);
      repeat (3) gap(n);
      chk(n[15:0], row_gap[i][15:0]);
    end
    wr_reg(4'h0, 8'h06);
    repeat (3) gap(n);
    chk(n[15:0], 16'h0080);
    $display("divider rows done");
    repeat (20000) @(posedge clk);
    wr_reg(4'h1, 8'h07);
    rd_reg(4'h1, v);
    chk({v, guard}, 9'h00F);
    wr_reg(4'h0, 8'h00);
    repeat (3) gap(n);
    chk(n[15:0], 16'h0001);
    wr_reg(4'h1, 8'h05);
    repeat (8) @(posedge clk);
    wr_reg(4'h1, 8'hF8);
    rd_reg(4'h1, v);
    chk({v, run, guard}, 10'h000);
    repeat (3) gap(n);
    chk(n[15:0], 16'h0004);
    $display("multiplier done");
    chk(oe, 1'b0);
    wr_reg(4'h2, 8'h02);
    wr_reg(4'h0, 8'h23);
    repeat (2) @(negedge clk);
    chk({oe, fbr}, 2'h3);
    mode_chk(3'h1, 1'b1, 1'b0);
    mode_chk(3'h2, 1'b1, 1'b1);
    mode_chk(3'h3, 1'b1, 1'b0);
    mode_chk(3'h4, 1'b0, 1'b0);
    mode_chk(3'h5, 1'b1, 1'b0);
    mode_chk(3'h0, 1'b1, 1'b1);
    $display("power modes done");
    wr_reg(4'h0, 8'h0B);
    repeat (41) @(posedge clk);
    rd_reg(4'h0, v);
    chk(v[4], 1'b1);
    repeat (3) gap(n);
    chk(n[15:0], 16'h0028);
    wr_reg(4'h0, 8'h4B);
    repeat (3) @(negedge clk);
    chk(osc, 1'b0);
    ticks(200, k, n);
    chk({k > 0, n > 0}, 2'h2);
    $display("subclock done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(4'h1, v);
    chk(v, 8'h01);
    $display("second reset done");
    stop_test;
  end
endmodule
`default_nettype wire
